// >>> logic/lhc_cfg.svh
// Offsets, field layout, reset values and timing counts of the section codec.
// Included by the package, the unpacker, the codec, the checkers and the bench; holds definitions only.
`ifndef LHC_CFG_SVH
`define LHC_CFG_SVH
// Register byte offsets on the register bus
`define LHC_ADR_RX_DATA 8'h00
`define LHC_ADR_CTRL 8'h04
`define LHC_ADR_RX_STAT 8'h08
`define LHC_ADR_LABEL 8'h0c
`define LHC_ADR_CHAN 8'h10
`define LHC_ADR_WIN 8'h14
`define LHC_ADR_RESULT 8'h18
`define LHC_ADR_TX_DATA 8'h1c
`define LHC_ADR_TX_STAT 8'h20
// Header word: code, word count, label, reserved low byte
`define LHC_W0_CODE 31:28
`define LHC_W0_COUNT 27:24
`define LHC_W0_LABEL 23:8
// Request word of channel and discovery requests
`define LHC_W1_DEFER 31:29
`define LHC_W1_BACKOFF 28:19
`define LHC_W1_OFFSET 18:9
`define LHC_W1_OCCUPY 8:5
`define LHC_W1_MODE 4:3
`define LHC_W1_PARTIAL 2
// Request word of window configuration requests
`define LHC_W1_NACK 31:24
`define LHC_W1_BLOCKS 23:16
`define LHC_W1_CLASS 15:13
// Response word; the result register uses the same bits plus the kind
`define LHC_RS_ID 31:20
`define LHC_RS_ACQ 19:18
`define LHC_RS_OUTCOME 17
`define LHC_RS_DISC 16
`define LHC_RS_OVF 15
`define LHC_RS_WINRX 14
`define LHC_RS_PARTIAL 13
`define LHC_RS_KIND 1:0
`define LHC_RSP_WORDS 4'h2
`define LHC_RESULT_RST 32'h0000_0000
// Field limits
`define LHC_OFFSET_MAX 10'h3e7
`define LHC_OCCUPY_MAX 4'ha
`define LHC_SF_MAX 4'h9
`define LHC_SYM_FULL 4'he
`define LHC_SYM_PART 4'h7
// Look-back windows of the partial sensing modes
`define LHC_CLK_MHZ 40
`define LHC_LOOKBACK_A_US 25
`define LHC_LOOKBACK_B_US 34
`define LHC_LOOKBACK_A_CYC (`LHC_LOOKBACK_A_US * `LHC_CLK_MHZ)
`define LHC_LOOKBACK_B_CYC (`LHC_LOOKBACK_B_US * `LHC_CLK_MHZ)
`endif

// >>> logic/lhc_pkg.sv
// Types of the handshake section codec.
// Assumes lhc_cfg.svh is on the include path.
`include "lhc_cfg.svh"
package lhc_pkg;
    typedef enum logic [3:0] {
        MC_SHARED_CHANNEL_REQUEST = 4'h0,
        MC_DISCOVERY_REQUEST = 4'h1,
        MC_SHARED_CHANNEL_RESPONSE = 4'h2,
        MC_DISCOVERY_RESPONSE = 4'h3,
        MC_OVERFLOW_REPORT = 4'h4,
        MC_WINDOW_CONFIG_REQUEST = 4'h5,
        MC_WINDOW_CONFIG_RESPONSE = 4'h6
    } lhc_msg_code_t;
    typedef enum logic [1:0] {
        SM_FULL_RESERVE = 2'h0,
        SM_LOOK_25 = 2'h1,
        SM_LOOK_34 = 2'h2,
        SM_FULL_STOP = 2'h3
    } lhc_sensing_mode_t;
    typedef enum logic [1:0] {
        RK_SHARED = 2'h0,
        RK_DISCOVERY = 2'h1,
        RK_OVERFLOW = 2'h2,
        RK_WINDOW = 2'h3
    } lhc_rsp_kind_t;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_FETCH0 = 5'b00010,
        ST_FETCH1 = 5'b00100,
        ST_FETCH2 = 5'b01000,
        ST_APPLY = 5'b10000
    } lhc_state_t;
endpackage

// >>> logic/lhc_fields_if.sv
// Decoded request fields passed from the unpacker to the codec core.
// Both ends share ref_clk; the fields are combinational.
`timescale 1ns/1ps
interface lhc_fields_if;
    logic [3:0] code;
    logic [3:0] wordCount;
    logic [15:0] requestLabel;
    logic [2:0] deferSlotFactor;
    logic [9:0] backoffSlotCount;
    logic [9:0] sensingStartOffsetUs;
    logic [3:0] maxOccupancySubframes;
    logic [1:0] sensingMode;
    logic firstSubframePartial;
    logic [7:0] windowNackCount;
    logic [7:0] windowBlockCount;
    logic [2:0] accessPriorityClass;
    modport producer (output code, wordCount, requestLabel, deferSlotFactor, backoffSlotCount,
        sensingStartOffsetUs, maxOccupancySubframes, sensingMode, firstSubframePartial,
        windowNackCount, windowBlockCount, accessPriorityClass);
    modport consumer (input code, wordCount, requestLabel, deferSlotFactor, backoffSlotCount,
        sensingStartOffsetUs, maxOccupancySubframes, sensingMode, firstSubframePartial,
        windowNackCount, windowBlockCount, accessPriorityClass);
endinterface

// >>> logic/lhc_section_ram.sv
// Word store for one received section, registered read data.
// Assumes a single clock; no reset, contents are written before use.
`timescale 1ns/1ps
module lhc_section_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic ref_clk,
    // Write port
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // Read port
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Write, and read one cycle after the address
    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// >>> logic/lhc_field_unpack.sv
// Splits the header and request word of a section into its fields.
// Assumes the layout macros of lhc_cfg.svh; reserved bits are not looked at.
`timescale 1ns/1ps
`include "lhc_cfg.svh"
module lhc_field_unpack (
    // Section words
    input wire logic [31:0] word0,
    input wire logic [31:0] word1,
    // Decoded fields
    lhc_fields_if.producer fields
);
    // Each field is taken most significant bit first from its layout slot
    assign fields.code = word0[`LHC_W0_CODE];
    assign fields.wordCount = word0[`LHC_W0_COUNT];
    assign fields.requestLabel = word0[`LHC_W0_LABEL];
    assign fields.deferSlotFactor = word1[`LHC_W1_DEFER];
    assign fields.backoffSlotCount = word1[`LHC_W1_BACKOFF];
    assign fields.sensingStartOffsetUs = word1[`LHC_W1_OFFSET];
    assign fields.maxOccupancySubframes = word1[`LHC_W1_OCCUPY];
    assign fields.sensingMode = word1[`LHC_W1_MODE];
    assign fields.firstSubframePartial = word1[`LHC_W1_PARTIAL];
    assign fields.windowNackCount = word1[`LHC_W1_NACK];
    assign fields.windowBlockCount = word1[`LHC_W1_BLOCKS];
    assign fields.accessPriorityClass = word1[`LHC_W1_CLASS];
endmodule

// >>> logic/lhc_section_codec.sv
// Handshake section codec of the radio unit: takes request sections word by word
// over classic Wishbone, decodes them, and builds response sections from results.
// Assumes one 40 MHz clock and software that feeds and drains the section words.
`timescale 1ns/1ps
`include "lhc_cfg.svh"

module lhc_section_codec
    import lhc_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o
);
    localparam int AW = $clog2(DEPTH);

    lhc_fields_if fields ();
    lhc_state_t state_r, state_nxt;
    logic ack_nxt;
    logic [31:0] datOut_nxt;
    logic [AW-1:0] wrIdx_r, wrIdx_nxt;
    logic [3:0] expWords_r, expWords_nxt;
    logic [31:0] word0_r, word0_nxt, word1_r, word1_nxt;
    logic [31:0] rdData;
    logic [AW-1:0] rdAddr;
    logic ramWr;
    logic reqValid_r, reqValid_nxt, codeDiscard_r, codeDiscard_nxt;
    logic lenError_r, lenError_nxt, paramWarn_r, paramWarn_nxt;
    logic overflow_r, overflow_nxt;
    logic [15:0] label_r, label_nxt;
    logic [31:0] chan_r, chan_nxt, win_r, win_nxt;
    logic [31:0] result_r, result_nxt;
    logic txReady_r, txReady_nxt, txIdx_r, txIdx_nxt;
    logic [10:0] lookback_r, lookback_nxt;
    logic busWr, busRd, rxWrite, ctrlWrite, statClear;
    logic [31:0] wmask, txWord0, txWord1, rspWord;
    logic [3:0] rspCode;
    logic [3:0] firstSymbols;

    lhc_section_ram #(
        .WIDTH(32),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_ram (
        .ref_clk(ref_clk),
        .wrEn(ramWr),
        .wrAddr(wrIdx_r),
        .wrData(wb_dat_i),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    lhc_field_unpack u_unpack (
        .word0(word0_r),
        .word1(word1_r),
        .fields(fields.producer)
    );

    // Accesses act at the edge where the master sees ack, so data is still held then
    assign busWr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    assign busRd = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Only full-word writes are taken as section data; partial ones would tear a word
    assign rxWrite = busWr && (wb_adr_i == `LHC_ADR_RX_DATA) && (wb_sel_i == 4'hf);
    assign ctrlWrite = busWr && (wb_adr_i == `LHC_ADR_CTRL) && wb_sel_i[0];
    assign statClear = ctrlWrite && wb_dat_i[0];
    assign ramWr = rxWrite && state_r == ST_IDLE;

    // symbol count of the first subframe
    assign firstSymbols = chan_r[`LHC_W1_PARTIAL] ? `LHC_SYM_PART : `LHC_SYM_FULL;

    // Response words built from the result register
    always_comb
    begin
        rspWord = 32'h0;
        rspWord[`LHC_RS_ID] = result_r[`LHC_RS_ID];
        rspWord[`LHC_RS_PARTIAL] = result_r[`LHC_RS_PARTIAL];
        case (lhc_rsp_kind_t'(result_r[`LHC_RS_KIND]))
            RK_SHARED:
            begin
                rspCode = MC_SHARED_CHANNEL_RESPONSE;
                rspWord[`LHC_RS_ACQ] = result_r[`LHC_RS_ACQ];
                rspWord[`LHC_RS_OUTCOME] = result_r[`LHC_RS_OUTCOME];
            end
            RK_DISCOVERY:
            begin
                rspCode = MC_DISCOVERY_RESPONSE;
                rspWord[`LHC_RS_DISC] = result_r[`LHC_RS_DISC];
            end
            RK_OVERFLOW:
            begin
                rspCode = MC_OVERFLOW_REPORT;
                // flag is always one, zero is reserved
                rspWord[`LHC_RS_OVF] = 1'b1;
            end
            RK_WINDOW:
            begin
                rspCode = MC_WINDOW_CONFIG_RESPONSE;
                rspWord[`LHC_RS_WINRX] = result_r[`LHC_RS_WINRX];
                rspWord[`LHC_RS_ID] = 12'h000;
            end
            default:
            begin
                rspCode = MC_SHARED_CHANNEL_RESPONSE;
            end
        endcase
        // label echoed; length counts the header word too
        txWord0 = {rspCode, `LHC_RSP_WORDS, label_r, 8'h00};
        txWord1 = rspWord;
    end

    // Bus answer: ack one cycle after the request, dropped in the cycle after it
    always_comb
    begin
        ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
        datOut_nxt = 32'h0;
        case (wb_adr_i)
            `LHC_ADR_RX_STAT:
            begin
                datOut_nxt = {12'h000, firstSymbols, expWords_r, fields.code, 2'b00,
                    (lookback_r != 11'h000), overflow_r, paramWarn_r, lenError_r,
                    codeDiscard_r, reqValid_r};
            end
            `LHC_ADR_LABEL:
            begin
                datOut_nxt = {16'h0000, label_r};
            end
            `LHC_ADR_CHAN:
            begin
                datOut_nxt = chan_r;
            end
            `LHC_ADR_WIN:
            begin
                datOut_nxt = win_r;
            end
            `LHC_ADR_RESULT:
            begin
                datOut_nxt = result_r;
            end
            `LHC_ADR_TX_DATA:
            begin
                datOut_nxt = !txReady_r ? 32'h0 : (txIdx_r ? txWord1 : txWord0);
            end
            `LHC_ADR_TX_STAT:
            begin
                datOut_nxt = {30'h0, txIdx_r, txReady_r};
            end
            default:
            begin
                datOut_nxt = 32'h0;
            end
        endcase
        // Data only in the ack cycle; the held request must not load it a second time
        if (!(ack_nxt && !wb_we_i))
        begin
            datOut_nxt = 32'h0;
        end
    end

    // Receive path, decode sequence and sticky status
    always_comb
    begin
        state_nxt = state_r;
        wrIdx_nxt = wrIdx_r;
        expWords_nxt = expWords_r;
        word0_nxt = word0_r;
        word1_nxt = word1_r;
        reqValid_nxt = reqValid_r && !statClear;
        codeDiscard_nxt = codeDiscard_r && !statClear;
        lenError_nxt = lenError_r && !statClear;
        paramWarn_nxt = paramWarn_r && !statClear;
        overflow_nxt = overflow_r && !statClear;
        label_nxt = label_r;
        chan_nxt = chan_r;
        win_nxt = win_r;
        rdAddr = '0;
        if (ctrlWrite && wb_dat_i[1])
        begin
            wrIdx_nxt = '0;
        end
        case (state_r)
            ST_IDLE:
            begin
                if (rxWrite)
                begin
                    // the header word gives the section length
                    expWords_nxt = (wrIdx_r == '0) ? wb_dat_i[`LHC_W0_COUNT] : expWords_r;
                    wrIdx_nxt = wrIdx_r + 1'b1;
                    if (wrIdx_r == '0 && wb_dat_i[`LHC_W0_COUNT] == 4'h0)
                    begin
                        // zero length is refused and the section dropped
                        lenError_nxt = 1'b1;
                        wrIdx_nxt = '0;
                    end
                    else if (32'(wrIdx_r) + 1 == 32'(expWords_nxt))
                    begin
                        wrIdx_nxt = '0;
                        state_nxt = ST_FETCH0;
                    end
                    else if (32'(wrIdx_r) == DEPTH - 1)
                    begin
                        // more data than the buffer holds
                        overflow_nxt = 1'b1;
                        wrIdx_nxt = '0;
                    end
                end
            end
            ST_FETCH0:
            begin
                rdAddr = '0;
                state_nxt = ST_FETCH1;
            end
            ST_FETCH1:
            begin
                rdAddr = AW'(1);
                word0_nxt = rdData;
                state_nxt = ST_FETCH2;
            end
            ST_FETCH2:
            begin
                word1_nxt = (expWords_r > 4'h1) ? rdData : 32'h0;
                state_nxt = ST_APPLY;
            end
            ST_APPLY:
            begin
                state_nxt = ST_IDLE;
                case (fields.code)
                    // request codes from the distributed unit
                    MC_SHARED_CHANNEL_REQUEST, MC_DISCOVERY_REQUEST:
                    begin
                        reqValid_nxt = 1'b1;
                        label_nxt = fields.requestLabel;
                        // reserved request bits are not kept
                        chan_nxt = 32'h0;
                        chan_nxt[`LHC_W0_CODE] = fields.code;
                        chan_nxt[`LHC_W1_DEFER] = fields.deferSlotFactor;
                        // backoff taken as a plain slot count
                        chan_nxt[`LHC_W1_BACKOFF] = fields.backoffSlotCount;
                        chan_nxt[`LHC_W1_OFFSET] = fields.sensingStartOffsetUs;
                        chan_nxt[`LHC_W1_OCCUPY] = fields.maxOccupancySubframes;
                        chan_nxt[`LHC_W1_MODE] = fields.sensingMode;
                        chan_nxt[`LHC_W1_PARTIAL] = fields.firstSubframePartial;
                        // out-of-range values are flagged, still kept
                        if (!(fields.deferSlotFactor inside {3'h1, 3'h3, 3'h7})
                            || fields.sensingStartOffsetUs > `LHC_OFFSET_MAX
                            || fields.maxOccupancySubframes == 4'h0
                            || fields.maxOccupancySubframes > `LHC_OCCUPY_MAX)
                        begin
                            paramWarn_nxt = 1'b1;
                        end
                    end
                    MC_WINDOW_CONFIG_REQUEST:
                    begin
                        reqValid_nxt = 1'b1;
                        label_nxt = fields.requestLabel;
                        win_nxt = {fields.windowNackCount, fields.windowBlockCount,
                            fields.accessPriorityClass, 13'h0000};
                        if (fields.accessPriorityClass == 3'h0 || fields.accessPriorityClass > 3'h4)
                        begin
                            paramWarn_nxt = 1'b1;
                        end
                    end
                    default:
                    begin
                        // reserved and misdirected codes are dropped unused
                        codeDiscard_nxt = 1'b1;
                    end
                endcase
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        // words arriving while a section is decoded are lost
        if (rxWrite && state_r != ST_IDLE)
        begin
            overflow_nxt = 1'b1;
        end
        // Set wins over a clear in the same cycle
        if (state_r == ST_APPLY && statClear)
        begin
            reqValid_nxt = reqValid_nxt || fields.code inside {4'h0, 4'h1, 4'h5};
        end
    end

    // Transmit side, result register and look-back timer
    always_comb
    begin
        result_nxt = result_r;
        txReady_nxt = txReady_r;
        txIdx_nxt = txIdx_r;
        lookback_nxt = (lookback_r != 11'h000) ? lookback_r - 11'h001 : lookback_r;
        if (busWr && wb_adr_i == `LHC_ADR_RESULT)
        begin
            // subframe numbers above 9 are clipped to 9
            result_nxt = (result_r & ~wmask) | (wb_dat_i & wmask);
            if (result_nxt[23:20] > `LHC_SF_MAX)
            begin
                result_nxt[23:20] = `LHC_SF_MAX;
            end
            txReady_nxt = 1'b1;
            txIdx_nxt = 1'b0;
        end
        if (busRd && wb_adr_i == `LHC_ADR_TX_DATA && txReady_r)
        begin
            txIdx_nxt = !txIdx_r;
            if (txIdx_r)
            begin
                txReady_nxt = 1'b0;
                // an expired timer resets the sensing process
                if (result_r[`LHC_RS_KIND] == RK_SHARED && result_r[`LHC_RS_ACQ] == 2'h3)
                begin
                    lookback_nxt = 11'h000;
                end
            end
        end
        if (ctrlWrite && wb_dat_i[2])
        begin
            txReady_nxt = 1'b0;
            txIdx_nxt = 1'b0;
        end
        // partial modes of a shared channel request arm their look-back window
        if (state_r == ST_APPLY && fields.code == MC_SHARED_CHANNEL_REQUEST)
        begin
            if (fields.sensingMode == SM_LOOK_25)
            begin
                lookback_nxt = 11'(`LHC_LOOKBACK_A_CYC);
            end
            else if (fields.sensingMode == SM_LOOK_34)
            begin
                lookback_nxt = 11'(`LHC_LOOKBACK_B_CYC);
            end
            else
            begin
                lookback_nxt = 11'h000;
            end
        end
    end

    // All state registers
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            state_r <= ST_IDLE;
            wrIdx_r <= '0;
            expWords_r <= 4'h0;
            word0_r <= 32'h0;
            word1_r <= 32'h0;
            reqValid_r <= 1'b0;
            codeDiscard_r <= 1'b0;
            lenError_r <= 1'b0;
            paramWarn_r <= 1'b0;
            overflow_r <= 1'b0;
            label_r <= 16'h0000;
            chan_r <= 32'h0;
            win_r <= 32'h0;
            result_r <= `LHC_RESULT_RST;
            txReady_r <= 1'b0;
            txIdx_r <= 1'b0;
            lookback_r <= 11'h000;
        end
        else
        begin
            wb_ack_o <= ack_nxt;
            wb_dat_o <= datOut_nxt;
            state_r <= state_nxt;
            wrIdx_r <= wrIdx_nxt;
            expWords_r <= expWords_nxt;
            word0_r <= word0_nxt;
            word1_r <= word1_nxt;
            reqValid_r <= reqValid_nxt;
            codeDiscard_r <= codeDiscard_nxt;
            lenError_r <= lenError_nxt;
            paramWarn_r <= paramWarn_nxt;
            overflow_r <= overflow_nxt;
            label_r <= label_nxt;
            chan_r <= chan_nxt;
            win_r <= win_nxt;
            result_r <= result_nxt;
            txReady_r <= txReady_nxt;
            txIdx_r <= txIdx_nxt;
            lookback_r <= lookback_nxt;
        end
    end
endmodule

// >>> verification/lhc_section_codec_asserts.sv
// Port checks of the section codec: bus handshake and read-back of fixed bits.
// Assumes a classic single-cycle Wishbone master.
`timescale 1ns/1ps
`include "lhc_cfg.svh"
module lhc_section_codec_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // A fresh read of one address, before its ack
    sequence s_rd(a);
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a;
    endsequence
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
    a_ctrl_zero: assert property (s_rd(`LHC_ADR_CTRL) |=> wb_dat_o == 32'h0) else $error("ctrl");
    a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
        wb_adr_i > `LHC_ADR_TX_STAT |=> wb_dat_o == 32'h0) else $error("unmapped");
    a_txstat_rsv: assert property (s_rd(`LHC_ADR_TX_STAT) |=> wb_dat_o[31:2] == 30'h0) else $error("txstat");
    a_win_rsv: assert property (s_rd(`LHC_ADR_WIN) |=> wb_dat_o[12:0] == 13'h0) else $error("win");
    a_sym_count: assert property (s_rd(`LHC_ADR_RX_STAT) |=>
        wb_dat_o[19:16] inside {4'h0, `LHC_SYM_FULL, `LHC_SYM_PART}) else $error("symbols");
endmodule
bind lhc_section_codec lhc_section_codec_asserts chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o));

// >>> verification/lhc_du_model.sv
// Request words of the distributed unit side.
// Assumes the word1 layout of the codec.
`timescale 1ns/1ps
module lhc_du_model (
    // Request words
    output logic [31:0] chanWord,
    output logic [31:0] winWord
);
    assign chanWord = {3'h3, 10'h3ff, 10'h3e7, 4'ha, 2'h1, 1'h1, 2'h0};
    // class 5 is sent on purpose so that it is flagged
    assign winWord = {8'hff, 8'h80, 3'h5, 13'h0};
endmodule

// >>> verification/lhc_section_codec_test.sv
// Self-checking bench of the section codec over classic Wishbone.
// Assumes the register map and timing of the codec's config header.
`timescale 1ns/1ps
`include "lhc_cfg.svh"
module lhc_section_codec_test;
    localparam logic [15:0] LBL = 16'hbeef;
    localparam logic [3:0] CODES [4] = '{4'h2, 4'h3, 4'h4, 4'h6};
    localparam logic [31:0] MSK [4] = '{32'hfffe_0000, 32'h1_0000, 32'h8000, 32'h4000};
    localparam logic [31:0] EXP [4] = '{32'hff9a_0000, 32'h1_0000, 32'h8000, 32'h4000};
    logic ref_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, chanWord, winWord;
    int mismatches = 0, samples_checked = 0;
    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;
    lhc_du_model du (.chanWord(chanWord), .winWord(winWord));
    lhc_section_codec uut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat));
    // One classic cycle; data is taken at the ack edge, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        samples_checked++;
        if ((q & m) !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, q & m, e);
        end
    endtask
    // Clears status and index, sends a section, waits out the decode
    task automatic sect(input logic [3:0] c, input logic [3:0] n, input logic [15:0] l, input logic [31:0] w1);
        wr(`LHC_ADR_CTRL, 32'h3);
        wr(`LHC_ADR_RX_DATA, {c, n, l, 8'h00});
        if (n > 4'h1)
            wr(`LHC_ADR_RX_DATA, w1);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rdc(`LHC_ADR_RESULT, '1, `LHC_RESULT_RST);
        rdc(`LHC_ADR_CTRL, '1, 32'h0);
        rdc(8'h40, '1, 32'h0);
        $display("test reset done");
        sect(4'h0, 4'h2, LBL, chanWord);
        rdc(`LHC_ADR_LABEL, 32'hffff, LBL);
        rdc(`LHC_ADR_CHAN, 32'h1fff_ffff, chanWord & 32'h1fff_ffff);
        rdc(`LHC_ADR_RX_STAT, 32'hf_ff3f, 32'h7_2021);
        $display("test request done");
        for (int k = 0; k < 4; k++)
        begin
            wr(`LHC_ADR_RESULT, 32'hfffb_4000 | k);
            rdc(`LHC_ADR_TX_DATA, '1, {CODES[k], `LHC_RSP_WORDS, LBL, 8'h00});
            rdc(`LHC_ADR_TX_DATA, MSK[k], EXP[k]);
        end
        rdc(`LHC_ADR_TX_STAT, '1, 32'h0);
        $display("test responses done");
        repeat (1000) @(posedge ref_clk);
        rdc(`LHC_ADR_RX_STAT, 32'h20, 32'h0);
        sect(4'h0, 4'h2, LBL, chanWord);
        wr(`LHC_ADR_RESULT, 32'h000c_0000);
        rdc(`LHC_ADR_TX_DATA, '1, {4'h2, `LHC_RSP_WORDS, LBL, 8'h00});
        rdc(`LHC_ADR_TX_DATA, '1, 32'h000c_0000);
        rdc(`LHC_ADR_RX_STAT, 32'h20, 32'h0);
        sect(4'h7, 4'h2, 16'h1234, chanWord);
        rdc(`LHC_ADR_RX_STAT, 32'h2, 32'h2);
        rdc(`LHC_ADR_LABEL, 32'hffff, LBL);
        sect(4'h0, 4'h0, 16'h1234, 32'h0);
        rdc(`LHC_ADR_RX_STAT, 32'h4, 32'h4);
        sect(4'h5, 4'h2, LBL, winWord);
        rdc(`LHC_ADR_WIN, '1, winWord);
        rdc(`LHC_ADR_RX_STAT, 32'h8, 32'h8);
        // A word written straight after a section lands while it is still decoded
        wr(`LHC_ADR_CTRL, 32'h3);
        wr(`LHC_ADR_RX_DATA, {4'h5, 4'h2, LBL, 8'h00});
        wr(`LHC_ADR_RX_DATA, winWord);
        wr(`LHC_ADR_RX_DATA, 32'h5200_0000);
        repeat (3) @(posedge ref_clk);
        rdc(`LHC_ADR_RX_STAT, 32'h10, 32'h10);
        $display("test errors done");
        close_out();
    end
    // Watchdog: the tests need about 1170 cycles
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        mismatches++;
        close_out();
    end
endmodule
